// File: inc/rtm_pkg.sv
package rtm_pkg;

  // Retirement slots reported per cycle
  localparam int RETIRE_SLOT_COUNT = 1;

  // Record widths
  localparam int REC_W = 14;
  localparam int WU_CAUSE_W = 11;
  localparam int ECAUSE_W = 6;
  localparam int DCAUSE_W = 3;
  localparam int CTYPE_W = 2;

  // Trap record field positions
  localparam int TRAP_F_TRAP = 0;
  localparam int TRAP_F_EXC = 1;
  localparam int TRAP_F_DBG = 2;
  localparam int TRAP_F_ECAUSE_LO = 3;
  localparam int TRAP_F_DCAUSE_LO = 9;
  localparam int TRAP_F_CTYPE_LO = 12;

  // Wakeup record field positions
  localparam int WU_F_WU = 0;
  localparam int WU_F_IRQ = 1;
  localparam int WU_F_DBG = 2;
  localparam int WU_F_CAUSE_LO = 3;

  // Debug cause codes
  localparam logic [2:0] DBG_NONE = 3'h0;
  localparam logic [2:0] DBG_EBREAK = 3'h1;
  localparam logic [2:0] DBG_TRIGGER = 3'h2;
  localparam logic [2:0] DBG_EXT = 3'h3;
  localparam logic [2:0] DBG_STEP = 3'h4;

  // Exception codes
  localparam logic [5:0] EXC_INSTR_ACCESS = 6'h01;
  localparam logic [5:0] EXC_ILLEGAL = 6'h02;
  localparam logic [5:0] EXC_BREAKPOINT = 6'h03;
  localparam logic [5:0] EXC_LOAD_ACCESS = 6'h05;
  localparam logic [5:0] EXC_STORE_ACCESS = 6'h07;
  localparam logic [5:0] EXC_ECALL_U = 6'h08;
  localparam logic [5:0] EXC_ECALL_M = 6'h0B;
  localparam logic [5:0] EXC_IBUS_FAULT = 6'h30;
  localparam logic [5:0] EXC_IPARITY = 6'h31;

  // Cause types
  localparam logic [1:0] CT_0 = 2'h0;
  localparam logic [1:0] CT_1 = 2'h1;
  localparam logic [1:0] CT_2 = 2'h2;

  // Register byte offsets
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_ORDER_LO = 12'h004;
  localparam logic [11:0] REG_ORDER_HI = 12'h008;
  localparam logic [11:0] REG_LAST_TRAP = 12'h00C;
  localparam logic [11:0] REG_PENDING = 12'h010;

  // Control bits and reset value
  localparam int CTRL_F_EN = 0;
  localparam int CTRL_F_CLR = 1;
  localparam logic CTRL_EN_RESET = 1'b1;

  // Fault source of a retiring instruction
  typedef enum logic [3:0] {
    TK_NONE,
    TK_IFETCH_ATTR,
    TK_IFETCH_PROT,
    TK_ILLEGAL,
    TK_EBREAK,
    TK_LOAD_IO_MISAL,
    TK_LOAD_PROT,
    TK_STORE_IO_MISAL,
    TK_STORE_PROT,
    TK_ECALL_U,
    TK_ECALL_M,
    TK_IFETCH_BUS,
    TK_IFETCH_PARITY,
    TK_TRIGGER
  } rtm_trap_kind_t;

endpackage : rtm_pkg

// File: rtl/rtm_trap_encode.sv
`timescale 1ns/100ps
module rtm_trap_encode
(
  // Instruction event
  input wire rtm_pkg::rtm_trap_kind_t kind,
  input wire logic in_dbg_mode,
  input wire logic ebreakm,
  input wire logic single_step,
  // Encoded result
  output logic [rtm_pkg::REC_W-1:0] trap_rec,
  output logic enters_debug,
  output logic [rtm_pkg::DCAUSE_W-1:0] dbg_cause
);
  import rtm_pkg::*;

  logic exc;
  logic dbg;
  logic [ECAUSE_W-1:0] ecause;
  logic [CTYPE_W-1:0] ctype;

  // Map the fault source onto flags, codes and cause type
  always_comb
  begin
    exc = 1'b0;
    dbg = 1'b0;
    ecause = '0;
    ctype = CT_0;
    dbg_cause = DBG_NONE;
    case (kind)
      TK_NONE: ;
      TK_IFETCH_ATTR:
      begin
        exc = 1'b1;
        ecause = EXC_INSTR_ACCESS;
      end
      TK_IFETCH_PROT:
      begin
        exc = 1'b1;
        ecause = EXC_INSTR_ACCESS;
        ctype = CT_1;
      end
      TK_ILLEGAL:
      begin
        exc = 1'b1;
        ecause = EXC_ILLEGAL;
      end
      TK_EBREAK:
      begin
        // Inside debug mode the jump back touches no CSRs
        if (in_dbg_mode || ebreakm)
        begin
          dbg = 1'b1;
          dbg_cause = DBG_EBREAK;
        end
        else
        begin
          exc = 1'b1;
          ecause = EXC_BREAKPOINT;
        end
      end
      TK_LOAD_IO_MISAL:
      begin
        exc = 1'b1;
        ecause = EXC_LOAD_ACCESS;
      end
      TK_LOAD_PROT:
      begin
        exc = 1'b1;
        ecause = EXC_LOAD_ACCESS;
        ctype = CT_2;
      end
      TK_STORE_IO_MISAL:
      begin
        exc = 1'b1;
        ecause = EXC_STORE_ACCESS;
      end
      TK_STORE_PROT:
      begin
        exc = 1'b1;
        ecause = EXC_STORE_ACCESS;
        ctype = CT_2;
      end
      TK_ECALL_U:
      begin
        exc = 1'b1;
        ecause = EXC_ECALL_U;
      end
      TK_ECALL_M:
      begin
        exc = 1'b1;
        ecause = EXC_ECALL_M;
      end
      TK_IFETCH_BUS:
      begin
        exc = 1'b1;
        ecause = EXC_IBUS_FAULT;
      end
      TK_IFETCH_PARITY:
      begin
        exc = 1'b1;
        ecause = EXC_IPARITY;
      end
      TK_TRIGGER:
      begin
        dbg = 1'b1;
        dbg_cause = DBG_TRIGGER;
      end
      default: ;
    endcase
    // A step keeps any exception flag; breakpoint or trigger cause wins
    if (single_step && !in_dbg_mode && !dbg)
    begin
      dbg = 1'b1;
      dbg_cause = DBG_STEP;
    end
  end

  // Pack the record
  always_comb
  begin
    trap_rec = '0;
    trap_rec[TRAP_F_TRAP] = exc | dbg;
    trap_rec[TRAP_F_EXC] = exc;
    trap_rec[TRAP_F_DBG] = dbg;
    trap_rec[TRAP_F_ECAUSE_LO +: ECAUSE_W] = ecause;
    trap_rec[TRAP_F_DCAUSE_LO +: DCAUSE_W] = dbg_cause;
    trap_rec[TRAP_F_CTYPE_LO +: CTYPE_W] = ctype;
    enters_debug = dbg;
  end

endmodule : rtm_trap_encode

// File: rtl/rtm_retire_monitor.sv
`timescale 1ns/100ps
// Overview of operation
// - Debug entry lies between instructions; handler record shows it.
// - Debug cause appears only on first handler instruction, else zero.
// - Debug cause codes: none 0, ebreak 1, trigger 2, external 3, step 4.
// - Debug-mode flag high for instructions executed in debug mode.
// - Two-bit pending NMI output, low bit set while an NMI pends.
// - NMI high bit is zero for loads, one for stores.
// - Sleep flag set on last instruction before sleep.
// - Wakeup flag set on first instruction after waking.
// - Wakeup record: flag 0, interrupt 1, debug 2, cause 13..3.
// - Wakeup interrupt/debug flags show the source; cause holds the code.
// - Outputs mean something only while valid is high.
// - Each retired or trapped instruction raises valid and bumps order.
// - Trap record: flags 2..0, cause 8..3, dcause 11..9, type 13..12.
// - Trap flag set for any synchronous exception or breakpoint, trigger or step debug entry; external entry leaves it clear.
// - Exception flag without debug entry; stepped exception sets both.
// - Cause type separates faults sharing one code.
// - A trap is followed next cycle by CSR effects and handler jump.
// - Breakpoint exception reports code 0x03, type 0.
// - Load fault 0x05, store 0x07; type 0 I/O misalign, 2 protection.
// - Environment call 0x08 from user, 0x0B from machine, type 0.
// - Fetch 0x01 (type 0 attr, 1 prot), bus 0x30, parity 0x31.
// - Debug causes: breakpoint 1, trigger 2, single step 4.
module rtm_retire_monitor
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core retirement, one entry per slot
  input wire logic [rtm_pkg::RETIRE_SLOT_COUNT-1:0] ret_valid,
  input wire logic [rtm_pkg::RETIRE_SLOT_COUNT-1:0][31:0] ret_pc,
  input wire logic [rtm_pkg::RETIRE_SLOT_COUNT-1:0] ret_dbg_mode,
  input wire rtm_pkg::rtm_trap_kind_t [rtm_pkg::RETIRE_SLOT_COUNT-1:0] ret_kind,
  input wire logic [rtm_pkg::RETIRE_SLOT_COUNT-1:0] ret_step,
  input wire logic [rtm_pkg::RETIRE_SLOT_COUNT-1:0] ret_sleep,
  // Core status
  input wire logic ebreakm,
  input wire logic nmi_pending,
  input wire logic nmi_store,
  input wire logic dbg_ext_entry,
  // Wakeup event
  input wire logic wake_event,
  input wire logic wake_irq,
  input wire logic wake_dbg,
  input wire logic [rtm_pkg::WU_CAUSE_W-1:0] wake_cause,
  // Trace outputs
  output logic [rtm_pkg::RETIRE_SLOT_COUNT-1:0] rvfi_valid,
  output logic [rtm_pkg::RETIRE_SLOT_COUNT-1:0][63:0] rvfi_order,
  output logic [rtm_pkg::RETIRE_SLOT_COUNT-1:0][31:0] rvfi_pc_rdata,
  output logic [rtm_pkg::RETIRE_SLOT_COUNT-1:0][2:0] rvfi_dbg,
  output logic [rtm_pkg::RETIRE_SLOT_COUNT-1:0] rvfi_dbg_mode,
  output logic [1:0] rvfi_nmip,
  output logic [rtm_pkg::RETIRE_SLOT_COUNT-1:0] rvfi_sleep,
  output logic [rtm_pkg::RETIRE_SLOT_COUNT-1:0][13:0] wakeup_record,
  output logic [rtm_pkg::RETIRE_SLOT_COUNT-1:0][13:0] rvfi_trap
);
  import rtm_pkg::*;

  localparam int N = RETIRE_SLOT_COUNT;

  typedef struct packed {
    logic en;
    logic [63:0] order;
    logic [2:0] dbg_pend;
    logic wu_pend;
    logic wu_irq;
    logic wu_dbg;
    logic [WU_CAUSE_W-1:0] wu_cause;
    logic [REC_W-1:0] last_trap;
    logic [N-1:0] valid;
    logic [N-1:0][63:0] ord;
    logic [N-1:0][31:0] pc;
    logic [N-1:0][2:0] dbg;
    logic [N-1:0] dmode;
    logic [1:0] nmip;
    logic [N-1:0] sleep;
    logic [N-1:0][REC_W-1:0] wu;
    logic [N-1:0][REC_W-1:0] trap;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } rtm_state_t;

  rtm_state_t st_q;
  rtm_state_t st_d;

  logic [N-1:0][REC_W-1:0] enc_rec;
  logic [N-1:0] enc_dbg;
  logic [N-1:0][DCAUSE_W-1:0] enc_dcause;
  logic apb_wr;

  // Register read mux; 1 in bit 32 flags an unmapped address
  function automatic logic [32:0] rtm_read(input logic [11:0] addr,
                                           input rtm_state_t s);
    logic [32:0] r;
    r = '0;
    case (addr)
      REG_CTRL: r[CTRL_F_EN] = s.en;
      REG_ORDER_LO: r[31:0] = s.order[31:0];
      REG_ORDER_HI: r[31:0] = s.order[63:32];
      REG_LAST_TRAP: r[REC_W-1:0] = s.last_trap;
      REG_PENDING: r[5:0] = {s.nmip, s.wu_pend, s.dbg_pend};
      default: r[32] = 1'b1;
    endcase
    return r;
  endfunction : rtm_read

  // One encoder per retirement slot
  for (genvar i = 0; i < N; i++)
  begin : g_slot
    rtm_trap_encode u_enc (
      .kind(ret_kind[i]),
      .in_dbg_mode(ret_dbg_mode[i]),
      .ebreakm(ebreakm),
      .single_step(ret_step[i]),
      .trap_rec(enc_rec[i]),
      .enters_debug(enc_dbg[i]),
      .dbg_cause(enc_dcause[i])
    );
  end

  // Write takes effect only in the access cycle the slave completes
  assign apb_wr = psel & penable & pwrite & st_q.pready;

  // Next-state logic for the whole block
  always_comb
  begin
    logic [32:0] rd;
    rd = '0;
    st_d = st_q;
    st_d.valid = '0;
    st_d.nmip = {nmi_pending & nmi_store, nmi_pending};

    // APB: answer in the cycle after setup, no wait states
    st_d.pready = 1'b0;
    st_d.pslverr = 1'b0;
    st_d.prdata = '0;
    if (psel && !penable)
    begin
      rd = rtm_read(paddr, st_q);
      st_d.pready = 1'b1;
      st_d.pslverr = rd[32];
      st_d.prdata = pwrite ? 32'h0000_0000 : rd[31:0];
    end
    if (apb_wr && (paddr == REG_CTRL))
    begin
      st_d.en = pwdata[CTRL_F_EN];
      if (pwdata[CTRL_F_CLR])
        st_d.order = '0;
    end

    // Walk slots in program order so pending causes land on the first
    for (int i = 0; i < N; i++)
    begin
      st_d.dbg[i] = DBG_NONE;
      st_d.wu[i] = '0;
      st_d.trap[i] = '0;
      st_d.sleep[i] = 1'b0;
      st_d.dmode[i] = 1'b0;
      st_d.pc[i] = ret_pc[i];
      st_d.ord[i] = st_d.order;
      if (ret_valid[i] && st_q.en)
      begin
        st_d.valid[i] = 1'b1;
        st_d.order = st_d.order + 64'h0000_0000_0000_0001;
        st_d.ord[i] = st_d.order;
        st_d.dmode[i] = ret_dbg_mode[i];
        st_d.sleep[i] = ret_sleep[i];
        st_d.trap[i] = enc_rec[i];
        // Handler's first instruction carries the cause, then it clears
        st_d.dbg[i] = st_d.dbg_pend;
        st_d.dbg_pend = DBG_NONE;
        if (st_d.wu_pend)
        begin
          st_d.wu[i][WU_F_WU] = 1'b1;
          st_d.wu[i][WU_F_IRQ] = st_d.wu_irq;
          st_d.wu[i][WU_F_DBG] = st_d.wu_dbg;
          st_d.wu[i][WU_F_CAUSE_LO +: WU_CAUSE_W] = st_d.wu_cause;
          st_d.wu_pend = 1'b0;
        end
        // The core applies CSR effects and jumps next cycle
        if (enc_rec[i][TRAP_F_TRAP])
          st_d.last_trap = enc_rec[i];
        if (enc_dbg[i])
          st_d.dbg_pend = enc_dcause[i];
      end
    end

    // Asynchronous debug request enters between instructions
    if (dbg_ext_entry && st_d.dbg_pend == DBG_NONE)
      st_d.dbg_pend = DBG_EXT;
    // New wakeup wins over the consumption in the same cycle
    if (wake_event)
    begin
      st_d.wu_pend = 1'b1;
      st_d.wu_irq = wake_irq;
      st_d.wu_dbg = wake_dbg;
      st_d.wu_cause = wake_cause;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= '0;
      st_q.en <= CTRL_EN_RESET;
    end
    else
      st_q <= st_d;
  end

  // Outputs come straight from the state register
  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign rvfi_valid = st_q.valid;
  assign rvfi_order = st_q.ord;
  assign rvfi_pc_rdata = st_q.pc;
  assign rvfi_dbg = st_q.dbg;
  assign rvfi_dbg_mode = st_q.dmode;
  assign rvfi_nmip = st_q.nmip;
  assign rvfi_sleep = st_q.sleep;
  assign wakeup_record = st_q.wu;
  assign rvfi_trap = st_q.trap;

  // Valid follows a retirement by one cycle
  property p_valid;
    @(posedge pclk) disable iff (!presetn)
    ret_valid[0] && st_q.en |=> rvfi_valid[0];
  endproperty
  a_valid: assert property (p_valid) else $error("valid missing");

  // Order advances by exactly one per record
  property p_order;
    @(posedge pclk) disable iff (!presetn)
    ret_valid[0] && st_q.en && !apb_wr
      |=> rvfi_order[0] == $past(st_q.order) + 64'h0000_0000_0000_0001;
  endproperty
  a_order: assert property (p_order) else $error("order step wrong");

  // Cause reported once, then zero on the following record
  property p_dbg_once;
    @(posedge pclk) disable iff (!presetn)
    rvfi_valid[0] && rvfi_dbg[0] != DBG_NONE && st_q.dbg_pend == DBG_NONE
      && !dbg_ext_entry && !(ret_valid[0] && enc_dbg[0]) ##1
      ret_valid[0] && st_q.en |=> rvfi_dbg[0] == DBG_NONE;
  endproperty
  a_dbg_once: assert property (p_dbg_once) else $error("cause kept");

  // Trigger entry shows cause 2 on the next record
  property p_trig;
    @(posedge pclk) disable iff (!presetn)
    ret_valid[0] && st_q.en && ret_kind[0] == TK_TRIGGER ##1
      ret_valid[0] && st_q.en |=> rvfi_dbg[0] == DBG_TRIGGER;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger cause lost");

  // Debug mode flag mirrors the core
  property p_dmode;
    @(posedge pclk) disable iff (!presetn)
    ret_valid[0] && st_q.en |=> rvfi_dbg_mode[0] == $past(ret_dbg_mode[0]);
  endproperty
  a_dmode: assert property (p_dmode) else $error("dbg mode wrong");

  // Store NMI shows both bits
  property p_nmip;
    @(posedge pclk) disable iff (!presetn)
    nmi_pending |=> rvfi_nmip == {$past(nmi_store), 1'b1};
  endproperty
  a_nmip: assert property (p_nmip) else $error("nmip wrong");

  // Wakeup flag lands on the next record after the event
  property p_wake;
    @(posedge pclk) disable iff (!presetn)
    wake_event ##1 ret_valid[0] && st_q.en |=> wakeup_record[0][WU_F_WU]
      && wakeup_record[0][WU_F_IRQ] == $past(wake_irq, 2);
  endproperty
  a_wake: assert property (p_wake) else $error("wakeup lost");

  // Trap flag is the OR of exception and debug flags
  property p_trapflag;
    @(posedge pclk) disable iff (!presetn)
    rvfi_valid[0] |-> rvfi_trap[0][TRAP_F_TRAP] ==
      (rvfi_trap[0][TRAP_F_EXC] | rvfi_trap[0][TRAP_F_DBG]);
  endproperty
  a_trapflag: assert property (p_trapflag) else $error("trap flag");

  // Machine ecall reports 0x0B, type 0
  property p_ecall;
    @(posedge pclk) disable iff (!presetn)
    ret_valid[0] && st_q.en && ret_kind[0] == TK_ECALL_M |=>
      rvfi_trap[0][TRAP_F_ECAUSE_LO +: ECAUSE_W] == EXC_ECALL_M
      && rvfi_trap[0][TRAP_F_CTYPE_LO +: CTYPE_W] == CT_0;
  endproperty
  a_ecall: assert property (p_ecall) else $error("ecall code");

  // Plain breakpoint becomes exception 0x03
  property p_ebreak;
    @(posedge pclk) disable iff (!presetn)
    ret_valid[0] && st_q.en && ret_kind[0] == TK_EBREAK && !ebreakm
      && !ret_dbg_mode[0] |=> rvfi_trap[0][TRAP_F_EXC]
      && rvfi_trap[0][TRAP_F_ECAUSE_LO +: ECAUSE_W] == EXC_BREAKPOINT;
  endproperty
  a_ebreak: assert property (p_ebreak) else $error("ebreak code");

endmodule : rtm_retire_monitor

// File: verification/rtm_trace_observer.sv
`timescale 1ns/100ps
// Far-side observer: counts qualified records, checks order steps
module rtm_trace_observer
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Trace port, slot 0
  input wire logic rvfi_valid,
  input wire logic [63:0] rvfi_order,
  // Bench tells us the count was cleared
  input wire logic resync,
  // Results
  output int rec_cnt,
  output int step_err
);
  logic [63:0] last_q;
  logic have_q;

  // Unqualified cycles carry garbage, so they are never looked at
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rec_cnt <= 0;
      step_err <= 0;
      have_q <= 1'b0;
    end
    else if (resync)
      have_q <= 1'b0;
    else if (rvfi_valid === 1'b1)
    begin
      rec_cnt <= rec_cnt + 1;
      if (have_q && rvfi_order !== last_q + 64'h1)
        step_err <= step_err + 1;
      last_q <= rvfi_order;
      have_q <= 1'b1;
    end
  end
endmodule : rtm_trace_observer

// File: verification/test_retirement_trace_monitor.sv
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
  begin \
    n_tests++; \
    if ((got) !== (ex)) \
    begin \
      mismatches++; \
      $display("[ERR] %s exp %h got %h", nm, ex, got); \
    end \
  end
module test_retirement_trace_monitor;
  import rtm_pkg::*;
  typedef struct {logic [31:0] pc; logic [2:0] dbg; logic dm, sl;
    logic [1:0] nm; logic [13:0] tr, tm, wu, wm;
    logic [63:0] ord;} rtm_exp_t;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, e, resync = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r;
  logic [0:0] ret_valid = 1'b0, ret_dbg_mode = 1'b0;
  logic [0:0] ret_step = 1'b0, ret_sleep = 1'b0;
  logic [0:0][31:0] ret_pc = '0;
  rtm_trap_kind_t [0:0] ret_kind = TK_NONE;
  logic ebreakm = 1'b0, nmi_pending = 1'b0, nmi_store = 1'b0;
  logic dbg_ext_entry = 1'b0, wake_event = 1'b0, wake_irq = 1'b0;
  logic wake_dbg = 1'b0;
  logic [10:0] wake_cause = 11'h000;
  logic [0:0] rvfi_valid, rvfi_dbg_mode, rvfi_sleep;
  logic [0:0][63:0] rvfi_order;
  logic [0:0][31:0] rvfi_pc_rdata;
  logic [0:0][2:0] rvfi_dbg;
  logic [1:0] rvfi_nmip;
  logic [0:0][13:0] wakeup_record, rvfi_trap;
  int mismatches = 0, n_tests = 0, pend = 0, cnt = 0, tot = 0;
  int rec_cnt, step_err;
  logic [13:0] wpend = '0;
  logic np = 1'b0, ns = 1'b0, ebm = 1'b0, en = 1'b1;
  logic [31:0] seed = 32'h0000_0d87, v;
  rtm_exp_t q[$];

  rtm_retire_monitor rtm_retire_monitor_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ret_valid(ret_valid), .ret_pc(ret_pc), .ret_dbg_mode(ret_dbg_mode),
    .ret_kind(ret_kind), .ret_step(ret_step), .ret_sleep(ret_sleep),
    .ebreakm(ebreakm), .nmi_pending(nmi_pending), .nmi_store(nmi_store),
    .dbg_ext_entry(dbg_ext_entry), .wake_event(wake_event),
    .wake_irq(wake_irq), .wake_dbg(wake_dbg), .wake_cause(wake_cause),
    .rvfi_valid(rvfi_valid), .rvfi_order(rvfi_order),
    .rvfi_pc_rdata(rvfi_pc_rdata), .rvfi_dbg(rvfi_dbg),
    .rvfi_dbg_mode(rvfi_dbg_mode), .rvfi_nmip(rvfi_nmip),
    .rvfi_sleep(rvfi_sleep), .wakeup_record(wakeup_record),
    .rvfi_trap(rvfi_trap));
  rtm_trace_observer rtm_trace_observer_i (.pclk(pclk), .presetn(presetn),
    .rvfi_valid(rvfi_valid[0]), .rvfi_order(rvfi_order[0]),
    .resync(resync), .rec_cnt(rec_cnt), .step_err(step_err));

  // Free-running core clock
  always #2 pclk = ~pclk;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  // Expected {cause type, exception code} of each fault source
  function automatic logic [7:0] code(rtm_trap_kind_t k);
    case (k)
      TK_IFETCH_ATTR: return 8'h01;
      TK_IFETCH_PROT: return 8'h41;
      TK_ILLEGAL: return 8'h02;
      TK_EBREAK: return 8'h03;
      TK_LOAD_IO_MISAL: return 8'h05;
      TK_LOAD_PROT: return 8'h85;
      TK_STORE_IO_MISAL: return 8'h07;
      TK_STORE_PROT: return 8'h87;
      TK_ECALL_U: return 8'h08;
      TK_ECALL_M: return 8'h0B;
      TK_IFETCH_BUS: return 8'h30;
      TK_IFETCH_PARITY: return 8'h31;
      default: return 8'h00;
    endcase
  endfunction : code

  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Answer and data are taken at the edge that samples pready high
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
      mismatches++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // One retirement; the model predicts its record at drive time
  task automatic ret(input rtm_trap_kind_t k, input logic dm, st, sl);
    rtm_exp_t x;
    logic deb, exc;
    logic [2:0] dc;
    logic [7:0] cd;
    @(posedge pclk);
    cd = code(k);
    x.pc = xs();
    x.ord = 64'(cnt + 1);
    deb = k == TK_TRIGGER || (k == TK_EBREAK && (ebm || dm));
    dc = k == TK_TRIGGER ? 3'h2 : 3'h1;
    exc = k != TK_NONE && !deb;
    if (st && !dm && !deb)
    begin
      deb = 1'b1;
      dc = 3'h4;
    end
    x.tr = {cd[7:6], dc, cd[5:0], deb, exc, exc | deb};
    x.tm = {{2{(exc || deb) && !st}}, {3{deb}}, {6{exc}}, 3'h7};
    x.dbg = pend[2:0];
    x.dm = dm;
    x.sl = sl;
    x.nm = {np & ns, np};
    x.wu = wpend;
    x.wm = wpend[0] ? 14'h3FFF : 14'h0001;
    ret_valid <= 1'b1;
    ret_pc[0] <= x.pc;
    ret_dbg_mode <= dm;
    ret_kind[0] <= k;
    ret_step <= st;
    ret_sleep <= sl;
    nmi_pending <= np;
    nmi_store <= ns;
    ebreakm <= ebm;
    // A disabled monitor drops the record but keeps what is pending
    if (en)
    begin
      q.push_back(x);
      cnt++;
      tot++;
      pend = deb ? int'(dc) : 0;
      wpend = '0;
    end
  endtask : ret

  // Wakeup event (w) or external debug entry between instructions
  task automatic pulse(input logic w, input logic [10:0] c,
    input logic i, d);
    @(posedge pclk);
    ret_valid <= 1'b0;
    if (w)
    begin
      wake_event <= 1'b1;
      wake_irq <= i;
      wake_dbg <= d;
      wake_cause <= c;
      wpend = {c, d, i, 1'b1};
    end
    else
    begin
      dbg_ext_entry <= 1'b1;
      if (pend == 0)
        pend = 3;
    end
    @(posedge pclk);
    wake_event <= 1'b0;
    dbg_ext_entry <= 1'b0;
  endtask : pulse

  task automatic idle(input string s);
    @(posedge pclk);
    ret_valid <= 1'b0;
    @(posedge pclk);
    $display("test %s done", s);
  endtask : idle

  task automatic summarize();
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  // Every qualified record is compared with the oldest prediction
  always @(negedge pclk)
  begin
    rtm_exp_t x;
    if (presetn && rvfi_valid[0] === 1'b1)
    begin
      if (q.size() == 0)
        `CHK("extra", 1'b0, 1'b1)
      else
      begin
        x = q.pop_front();
        `CHK("pc", x.pc, rvfi_pc_rdata[0])
        `CHK("order", x.ord, rvfi_order[0])
        `CHK("dbg", x.dbg, rvfi_dbg[0])
        `CHK("dmode", x.dm, rvfi_dbg_mode[0])
        `CHK("nmip", x.nm, rvfi_nmip)
        `CHK("sleep", x.sl, rvfi_sleep[0])
        `CHK("wu", x.wu & x.wm, wakeup_record[0] & x.wm)
        `CHK("trap", x.tr & x.tm, rvfi_trap[0] & x.tm)
      end
    end
  end

  // Watchdog: the whole run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge pclk);
    mismatches++;
    summarize();
  end

  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0000_0000);
    `CHK("ctrl_en", 1'b1, r[0])
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    `CHK("unmapped", 33'h1_0000_0000, {e, r})
    idle("registers");
    for (int k = 0; k < 14; k++)
    begin
      v = xs();
      np = v[0];
      ns = v[1];
      ret(rtm_trap_kind_t'(k), 1'b0, 1'b0, 1'b0);
    end
    idle("codes");
    apb(1'b0, 12'h00C, 32'h0000_0000);
    `CHK("last_trap", 6'h15, {r[11:9], r[2:0]})
    apb(1'b0, 12'h004, 32'h0000_0000);
    `CHK("order_lo", 32'(cnt), r)
    ebm = 1'b1;
    ret(TK_EBREAK, 1'b0, 1'b0, 1'b0);
    ret(TK_NONE, 1'b1, 1'b0, 1'b0);
    ret(TK_EBREAK, 1'b1, 1'b0, 1'b0);
    ret(TK_NONE, 1'b1, 1'b0, 1'b0);
    ebm = 1'b0;
    ret(TK_ILLEGAL, 1'b0, 1'b1, 1'b0);
    ret(TK_NONE, 1'b0, 1'b1, 1'b0);
    ret(TK_NONE, 1'b0, 1'b0, 1'b0);
    pulse(1'b0, 11'h000, 1'b0, 1'b0);
    ret(TK_NONE, 1'b1, 1'b0, 1'b0);
    ret(TK_TRIGGER, 1'b0, 1'b0, 1'b0);
    pulse(1'b0, 11'h000, 1'b0, 1'b0);
    ret(TK_NONE, 1'b1, 1'b0, 1'b0);
    idle("debug");
    ret(TK_NONE, 1'b0, 1'b0, 1'b1);
    pulse(1'b1, 11'h7FF, 1'b1, 1'b0);
    ret(TK_NONE, 1'b0, 1'b0, 1'b0);
    ret(TK_NONE, 1'b0, 1'b0, 1'b1);
    pulse(1'b1, 11'h2A5, 1'b0, 1'b1);
    ret(TK_NONE, 1'b0, 1'b0, 1'b0);
    idle("sleep");
    repeat (60)
    begin
      v = xs();
      np = v[20];
      ns = v[21];
      ebm = v[22];
      ret(rtm_trap_kind_t'(4'(v[15:0] % 14)), v[4], v[5], v[6]);
      if (v[9:7] == 3'h0)
        pulse(v[10], v[31:21], v[11], v[12]);
    end
    idle("random");
    apb(1'b1, 12'h000, 32'h0000_0000);
    en = 1'b0;
    repeat (3) ret(TK_NONE, 1'b0, 1'b0, 1'b0);
    idle("disabled");
    apb(1'b0, 12'h004, 32'h0000_0000);
    `CHK("order_frozen", 32'(cnt), r)
    apb(1'b1, 12'h000, 32'h0000_0003);
    en = 1'b1;
    cnt = 0;
    resync <= 1'b1;
    apb(1'b1, 12'h004, 32'hFFFF_FFFF);
    resync <= 1'b0;
    apb(1'b0, 12'h004, 32'h0000_0000);
    `CHK("order_clr", 33'h0_0000_0000, {e, r})
    repeat (2) ret(TK_NONE, 1'b0, 1'b0, 1'b0);
    idle("clear");
    apb(1'b0, 12'h004, 32'h0000_0000);
    `CHK("order_lo", 32'(cnt), r)
    apb(1'b0, 12'h008, 32'h0000_0000);
    `CHK("order_hi", 32'h0000_0000, r)
    `CHK("left", 0, q.size())
    `CHK("records", tot, rec_cnt)
    `CHK("order_step", 0, step_err)
    summarize();
  end
endmodule : test_retirement_trace_monitor
